// ---- logic/msl_pkg.sv ----
/*
 Package for the module status lamp driver: timing counts, lamp modes,
 and the packed structs that carry lamp and fault groups.
 Assumes a 50 MHz module clock.
*/
`default_nettype none
package msl_pkg;
	localparam int unsigned CLK_HZ        = 50_000_000;
	localparam int unsigned SLOW_FLASH_HZ = 4;
	localparam int unsigned FAST_FLASH_HZ = 8;
	localparam int unsigned CODE_FLASH_HZ = 2;
	localparam int unsigned PAUSE_MS      = 1000;
	// Half periods give a 50 percent duty cycle
	localparam int unsigned SLOW_HALF_CYC = CLK_HZ / (2 * SLOW_FLASH_HZ);
	localparam int unsigned FAST_HALF_CYC = CLK_HZ / (2 * FAST_FLASH_HZ);
	localparam int unsigned CODE_HALF_CYC = CLK_HZ / (2 * CODE_FLASH_HZ);
	localparam int unsigned PAUSE_CYC     = (CLK_HZ / 1000) * PAUSE_MS;
	localparam int unsigned NUM_AXES      = 4;
	localparam int unsigned CODE_W        = 16;
	localparam int unsigned BLINK_W       = 4;

	typedef enum logic [5:0] {
		MSL_DARK  = 6'h01,
		MSL_STEADY = 6'h02,
		MSL_SLOW  = 6'h04,
		MSL_FAST  = 6'h08,
		MSL_BOOT  = 6'h10,
		MSL_WDOG  = 6'h20
	} msl_mode_t;

	typedef struct packed {
		logic       status;
		logic       health;
		logic       config_lit;
		logic [3:0] axis_drive;
	} msl_lamps_t;

	typedef struct packed {
		logic              stat_only;
		logic              servo_stop;
		logic [CODE_W-1:0] code;
		logic [1:0]        axis_sel;
		logic              axis_fault;
	} msl_fault_t;
endpackage
`default_nettype wire

// ---- logic/msl_blinker.sv ----
/*
 Free-running square wave with a 50 percent duty cycle.
 Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module msl_blinker
	import msl_pkg::*;
#(
	parameter int unsigned HALF_CYC = 2
)(
	input  wire logic clk_in,
	input  wire logic rst_in,
	output var  logic wave_out
);
	localparam int CW = $clog2(HALF_CYC + 1);
	logic [CW-1:0] cnt_r;

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			cnt_r    <= '0;
			wave_out <= 1'b0;
		end
		else if (cnt_r == CW'(HALF_CYC - 1))
		begin
			cnt_r    <= '0;
			wave_out <= ~wave_out;
		end
		else
			cnt_r <= cnt_r + 1'b1;
	end
endmodule
`default_nettype wire

// ---- logic/msl_led_driver.sv ----
/*
 Front-panel status lamp driver: status, health, configuration and four
 axis drive lamps, plus the module fault flag and fault code words.
 Assumes all inputs are synchronous to clk_in; lamps are active high.
*/
// How it works
// - Status-only fault, config lamp lit: status flashes four per second.
// - Servo-stopping fault flashes the status lamp eight times per second.
// - Constant-rate fault flash raises fault flag and posts a fault code.
// - Status lamp steady in normal operation, flashes for faults, boot mode and watchdog timeout.
// - Boot mode flashes status and configuration lamps together.
// - Watchdog timeout flashes status and configuration lamps alternately.
// - Power-up malfunction: config dark, status blinks two counted bursts.
// - Status and health lamps dark when module cannot power up.
// - Health lamp steadily lit while the module is healthy.
// - Configuration lamp lit once configuration has been received.
// - Each axis lamp follows its drive-enable relay one clock later.
`timescale 1ns/1ps
`default_nettype none
module msl_led_driver
	import msl_pkg::*;
#(
	parameter int unsigned SLOW_HALF  = SLOW_HALF_CYC,
	parameter int unsigned FAST_HALF  = FAST_HALF_CYC,
	parameter int unsigned CODE_HALF  = CODE_HALF_CYC,
	parameter int unsigned PAUSE_LEN  = PAUSE_CYC
)(
	input  wire logic               clk_in,
	input  wire logic               rst_in,
	input  wire logic               powered_ok_in,
	input  wire logic               powerup_fault_in,
	input  wire logic [BLINK_W-1:0] first_number_in,
	input  wire logic [BLINK_W-1:0] second_number_in,
	input  wire logic               config_received_in,
	input  wire logic               boot_mode_in,
	input  wire logic               watchdog_timeout_in,
	input  wire msl_fault_t         fault_in,
	input  wire logic [3:0]         drive_relay_in,
	output var  msl_lamps_t         lamps_out,
	output var  logic               module_fault_out,
	output var  logic [CODE_W-1:0]  module_code_out,
	output var  logic [CODE_W-1:0]  axis_code_out [NUM_AXES]
);
	logic slow_w;
	logic fast_w;
	logic code_w;
	msl_mode_t mode_nxt;
	logic cfg_seen_r;

	msl_blinker #(.HALF_CYC(SLOW_HALF)) u_slow
	(
		.clk_in   (clk_in),
		.rst_in   (rst_in),
		.wave_out (slow_w)
	);
	msl_blinker #(.HALF_CYC(FAST_HALF)) u_fast
	(
		.clk_in   (clk_in),
		.rst_in   (rst_in),
		.wave_out (fast_w)
	);
	msl_blinker #(.HALF_CYC(CODE_HALF)) u_code
	(
		.clk_in   (clk_in),
		.rst_in   (rst_in),
		.wave_out (code_w)
	);

	// Power-up fault number display: burst A, pause, burst B, double-length gap, repeat
	typedef enum logic [3:0] {
		BC_IDLE   = 4'h1,
		BC_BURST  = 4'h2,
		BC_PAUSE  = 4'h4,
		BC_GAP    = 4'h8
	} msl_burst_t;
	msl_burst_t bc_state_r;
	logic               bc_second_r;
	logic [BLINK_W-1:0] bc_left_r;
	logic [31:0]        bc_cnt_r;
	logic               bc_lamp_r;
	logic               code_q_r;
	logic               code_fall;
	assign code_fall = code_q_r & ~code_w;

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			code_q_r <= 1'b0;
		else
			code_q_r <= code_w;
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			bc_state_r  <= BC_IDLE;
			bc_second_r <= 1'b0;
			bc_left_r   <= '0;
			bc_cnt_r    <= '0;
			bc_lamp_r   <= 1'b0;
		end
		else if (!powerup_fault_in)
		begin
			bc_state_r <= BC_IDLE;
			bc_lamp_r  <= 1'b0;
		end
		else
		begin
			unique case (bc_state_r)
				BC_IDLE:
				begin
					bc_second_r <= 1'b0;
					bc_left_r   <= first_number_in;
					bc_state_r  <= BC_BURST;
				end
				BC_BURST:
				begin
					bc_lamp_r <= code_w & (bc_left_r != '0);
					if (code_fall && bc_left_r != '0)
						bc_left_r <= bc_left_r - 1'b1;
					if (bc_left_r == '0 && !code_w)
					begin
						bc_cnt_r   <= '0;
						bc_state_r <= bc_second_r ? BC_GAP : BC_PAUSE;
					end
				end
				BC_PAUSE:
				begin
					bc_lamp_r <= 1'b0;
					bc_cnt_r  <= bc_cnt_r + 1;
					if (bc_cnt_r == 32'(PAUSE_LEN - 1))
					begin
						bc_second_r <= 1'b1;
						bc_left_r   <= second_number_in;
						bc_state_r  <= BC_BURST;
					end
				end
				BC_GAP:
				begin
					bc_lamp_r <= 1'b0;
					bc_cnt_r  <= bc_cnt_r + 1;
					// Long gap keeps the two numbers apart on repeat
					if (bc_cnt_r == 32'(2 * PAUSE_LEN - 1))
						bc_state_r <= BC_IDLE;
				end
			endcase
		end
	end

	always_comb
	begin
		if (!powered_ok_in || powerup_fault_in)
			mode_nxt = MSL_DARK;
		else if (boot_mode_in)
			mode_nxt = MSL_BOOT;
		else if (watchdog_timeout_in)
			mode_nxt = MSL_WDOG;
		else if (fault_in.servo_stop)
			mode_nxt = MSL_FAST;
		else if (fault_in.stat_only && cfg_seen_r)
			mode_nxt = MSL_SLOW;
		else
			mode_nxt = MSL_STEADY;
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			cfg_seen_r <= 1'b0;
		else if (config_received_in)
			cfg_seen_r <= 1'b1;
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			lamps_out <= '0;
		else
		begin
			lamps_out.axis_drive <= drive_relay_in;
			lamps_out.health <= powered_ok_in & ~powerup_fault_in;
			unique case (mode_nxt)
				MSL_DARK:
				begin
					lamps_out.status     <= powerup_fault_in & bc_lamp_r;
					lamps_out.config_lit <= 1'b0;
				end
				MSL_STEADY:
				begin
					lamps_out.status     <= 1'b1;
					lamps_out.config_lit <= cfg_seen_r;
				end
				MSL_SLOW:
				begin
					lamps_out.status     <= slow_w;
					lamps_out.config_lit <= cfg_seen_r;
				end
				MSL_FAST:
				begin
					lamps_out.status     <= fast_w;
					lamps_out.config_lit <= cfg_seen_r;
				end
				MSL_BOOT:
				begin
					lamps_out.status     <= slow_w;
					lamps_out.config_lit <= slow_w;
				end
				MSL_WDOG:
				begin
					lamps_out.status     <= slow_w;
					lamps_out.config_lit <= ~slow_w;
				end
			endcase
		end
	end

	// Fault flag and codes follow constant-rate fault flashing only
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			module_fault_out <= 1'b0;
			module_code_out  <= '0;
			for (int i = 0; i < NUM_AXES; i++)
				axis_code_out[i] <= '0;
		end
		else
		begin
			module_fault_out <= (mode_nxt == MSL_FAST)
				|| (mode_nxt == MSL_SLOW);
			if (mode_nxt == MSL_FAST || mode_nxt == MSL_SLOW)
			begin
				if (fault_in.axis_fault)
					axis_code_out[fault_in.axis_sel] <= fault_in.code;
				else
					module_code_out <= fault_in.code;
			end
		end
	end

	property p_axis_lamp;
		@(posedge clk_in) disable iff (rst_in)
		##1 lamps_out.axis_drive == $past(drive_relay_in);
	endproperty
	a_axis_lamp: assert property (p_axis_lamp) else $error("axis lamp");

	property p_steady;
		@(posedge clk_in) disable iff (rst_in)
		(powered_ok_in && !powerup_fault_in && !boot_mode_in
		&& !watchdog_timeout_in && !fault_in.servo_stop
		&& !fault_in.stat_only) |=> lamps_out.status;
	endproperty
	a_steady: assert property (p_steady) else $error("status not steady");

	// A detected power-up fault still blinks its numbers, so only a silent
	// failure to power up must leave both lamps dark
	property p_dark;
		@(posedge clk_in) disable iff (rst_in)
		(!powered_ok_in && !powerup_fault_in)
			|=> !lamps_out.status && !lamps_out.health;
	endproperty
	a_dark: assert property (p_dark) else $error("lamps not dark");

	property p_health;
		@(posedge clk_in) disable iff (rst_in)
		(powered_ok_in && !powerup_fault_in) |=> lamps_out.health;
	endproperty
	a_health: assert property (p_health) else $error("health dark");

	property p_cfg_hold;
		@(posedge clk_in) disable iff (rst_in)
		(cfg_seen_r && (mode_nxt == MSL_STEADY || mode_nxt == MSL_SLOW
		|| mode_nxt == MSL_FAST)) |=> lamps_out.config_lit;
	endproperty
	a_cfg_hold: assert property (p_cfg_hold) else $error("cfg lost");

	property p_fast;
		@(posedge clk_in) disable iff (rst_in)
		(mode_nxt == MSL_FAST) |=> lamps_out.status == $past(fast_w);
	endproperty
	a_fast: assert property (p_fast) else $error("fast rate wrong");

	property p_slow;
		@(posedge clk_in) disable iff (rst_in)
		(mode_nxt == MSL_SLOW) |=> lamps_out.status == $past(slow_w)
			&& module_fault_out;
	endproperty
	a_slow: assert property (p_slow) else $error("slow rate wrong");

	property p_boot;
		@(posedge clk_in) disable iff (rst_in)
		(mode_nxt == MSL_BOOT) |=> lamps_out.status == lamps_out.config_lit;
	endproperty
	a_boot: assert property (p_boot) else $error("boot not in phase");

	property p_wdog;
		@(posedge clk_in) disable iff (rst_in)
		(mode_nxt == MSL_WDOG) |=> lamps_out.status != lamps_out.config_lit;
	endproperty
	a_wdog: assert property (p_wdog) else $error("wdog not opposite");

	property p_pufault;
		@(posedge clk_in) disable iff (rst_in)
		powerup_fault_in |=> !lamps_out.config_lit;
	endproperty
	a_pufault: assert property (p_pufault) else $error("cfg lit");

	c_fast: cover property (@(posedge clk_in) mode_nxt == MSL_FAST);
	c_wdog: cover property (@(posedge clk_in) mode_nxt == MSL_WDOG);
	c_pause: cover property (@(posedge clk_in) bc_state_r == BC_PAUSE);
endmodule
`default_nettype wire

// ---- testbench/msl_panel.sv ----
/*
 Front panel lamp model: measures status lamp run lengths and counts blink
 bursts. Assumes lamps_in changes just after the rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module msl_panel
	import msl_pkg::*;
#(
	parameter int GAP = 12
)(
	input  wire logic       clk_in,
	input  wire logic       clr_in,
	input  wire msl_lamps_t lamps_in,
	output var  int         on_len_out,
	output var  int         off_len_out,
	output var  int         n_burst_out,
	output var  int         burst_out [4]
);
	logic prev;
	int   cnt;
	int   pulses;

	// A dark run of GAP cycles closes a burst; shorter gaps are blinks
	always @(posedge clk_in)
	begin
		if (clr_in)
		begin
			prev = 1'b0;
			cnt = 0;
			pulses = 0;
			n_burst_out = 0;
		end
		else if (lamps_in.status !== prev)
		begin
			if (prev)
				on_len_out = cnt;
			else
				off_len_out = cnt;
			if (lamps_in.status)
				pulses++;
			cnt = 1;
			prev = lamps_in.status;
		end
		else
		begin
			cnt++;
			if (!prev && cnt == GAP && pulses > 0 && n_burst_out < 4)
			begin
				burst_out[n_burst_out] = pulses;
				n_burst_out++;
				pulses = 0;
			end
		end
	end
endmodule
`default_nettype wire

// ---- testbench/tb_module_status_led_driver.sv ----
/*
 Self-checking bench for the status lamp driver with a lamp panel model.
 Assumes shortened flash counts: slow 4, fast 2, code 8, pause 20.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_module_status_led_driver
	import msl_pkg::*;
;
	localparam int SLW = 4;
	localparam int FST = 2;
	logic              clk, rst, pwr, pflt, cfg, boot, wd, clr;
	logic [3:0]        n1, n2, relay;
	msl_fault_t        flt;
	msl_lamps_t        lamps;
	logic              mflt;
	logic [CODE_W-1:0] mcode;
	logic [CODE_W-1:0] acode [NUM_AXES];
	int                on_len, off_len, nb, b [4];
	int                n_errors = 0;
	int                checked = 0;

	msl_led_driver #(.SLOW_HALF(SLW), .FAST_HALF(FST), .CODE_HALF(8),
		.PAUSE_LEN(20)) dut (.clk_in(clk), .rst_in(rst),
		.powered_ok_in(pwr), .powerup_fault_in(pflt),
		.first_number_in(n1), .second_number_in(n2),
		.config_received_in(cfg), .boot_mode_in(boot),
		.watchdog_timeout_in(wd), .fault_in(flt), .drive_relay_in(relay),
		.lamps_out(lamps), .module_fault_out(mflt),
		.module_code_out(mcode), .axis_code_out(acode));
	msl_panel #(.GAP(12)) panel (.clk_in(clk), .clr_in(clr),
		.lamps_in(lamps), .on_len_out(on_len), .off_len_out(off_len),
		.n_burst_out(nb), .burst_out(b));

	task automatic check(input bit ok, input string msg);
		checked++;
		if (!ok)
		begin
			n_errors++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic final_report();
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic t_normal();
		pwr = 1'b1;
		tick(3);
		check(lamps.status === 1'b1 && lamps.health === 1'b1, "steady");
		// Status-only fault is ignored until configured
		flt.stat_only = 1'b1;
		tick(12);
		check(lamps.status === 1'b1 && mflt === 1'b0, "unconfig");
		flt.stat_only = 1'b0;
		cfg = 1'b1;
		tick(1);
		cfg = 1'b0;
		tick(5);
		check(lamps.config_lit === 1'b1, "config lamp");
		for (int i = 0; i < 16; i++)
		begin
			relay = 4'(i);
			tick(2);
			check(lamps.axis_drive === 4'(i), "axis lamps");
		end
	endtask
	task automatic t_faults();
		flt.stat_only = 1'b1;
		flt.code = 16'hA5C3;
		tick(20);
		check(on_len == SLW && off_len == SLW, "slow rate");
		check(mflt === 1'b1 && mcode === 16'hA5C3, "module code");
		flt.servo_stop = 1'b1;
		flt.code = 16'h3B71;
		flt.axis_fault = 1'b1;
		flt.axis_sel = 2'h2;
		tick(16);
		check(on_len == FST && off_len == FST, "fast rate");
		check(mflt === 1'b1 && acode[2] === 16'h3B71, "axis code");
		flt = '0;
		tick(12);
		check(lamps.status === 1'b1 && mflt === 1'b0
			&& lamps.config_lit === 1'b1, "back steady");
	endtask
	task automatic t_pair(input bit alt);
		bit ok = 1'b1;
		tick(3);
		repeat (16)
		begin
			ok &= (lamps.status ^ lamps.config_lit) === alt;
			tick(1);
		end
		check(ok && on_len == SLW, "pair phase");
	endtask
	task automatic t_powerup();
		int i = 0;
		pwr = 1'b0;
		pflt = 1'b1;
		n1 = 4'h3;
		n2 = 4'h5;
		clr = 1'b1;
		tick(1);
		clr = 1'b0;
		tick(2);
		check(lamps.health === 1'b0 && lamps.config_lit === 1'b0, "dark");
		while (nb < 3 && i < 1000)
		begin
			tick(1);
			i++;
		end
		check((b[0] == 3 && b[1] == 5) || (b[1] == 3 && b[2] == 5), "bursts");
	endtask
	task automatic t_dead();
		bit ok = 1'b1;
		pflt = 1'b0;
		tick(3);
		repeat (10)
		begin
			ok &= lamps.status === 1'b0 && lamps.health === 1'b0;
			tick(1);
		end
		check(ok, "not powered");
	endtask

	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Whole sequence takes well under 2000 cycles
	initial
	begin
		#(20 * 5000);
		n_errors++;
		final_report();
	end
	initial
	begin
		rst = 1'b1;
		{pwr, pflt, cfg, boot, wd, n1, n2, relay} = '0;
		flt = '0;
		clr = 1'b1;
		tick(6);
		check(lamps === '0 && mflt === 1'b0, "reset");
		rst = 1'b0;
		clr = 1'b0;
		t_normal();
		t_faults();
		boot = 1'b1;
		t_pair(1'b0);
		boot = 1'b0;
		wd = 1'b1;
		t_pair(1'b1);
		wd = 1'b0;
		t_powerup();
		t_dead();
		final_report();
	end
endmodule
`default_nettype wire
